/* shared/serial_port_consts.svh */
// Purpose: offsets, bit positions, reset values of the serial control block
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes: included by bare name
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_CLR 8'h0C
`define OFS_IRQ_EN 8'h10

// ==========================================================
// Control register bits
`define CTRL_RX_EN 0
`define CTRL_TX_EN 1
`define CTRL_RX_IRQ_EN 2
`define CTRL_TX_IRQ_EN 3
`define CTRL_MP_IRQ_EN 4
`define CTRL_W 5
`define CTRL_RESET 5'h00

// ==========================================================
// Status register bits
`define ST_RX_FULL 0
`define ST_FER 1
`define ST_OER 2
`define ST_TX_EMPTY 3

// ==========================================================
// Interrupt status, clear and enable bits
`define EV_RX_FULL 0
`define EV_RX_ERR 1
`define EV_TX_EMPTY 2
`define EV_W 3
`define EV_RESET 3'h0

`endif

/* shared/serial_port_pkg.sv */
// Purpose: types of the serial control block
// Assumes: nothing
// Notes: used with package scope, never imported
package serial_port_pkg;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_st_e;

  typedef logic [31:0] word_t;

endpackage

/* design/serial_port_control_enables.sv */
// Purpose: control enables, pin hand-over and irq gating of a serial port
// Assumes: frame events come from a receiver on the same clock
// Notes: AHB-Lite slave with one wait state per transfer
`timescale 1ns/10ps
`include "serial_port_consts.svh"

module serial_port_control_enables (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic frame_valid,
  input wire logic frame_mp_bit,
  input wire logic frame_fer,
  input wire logic frame_oer,
  input wire logic tx_reg_empty,
  input wire logic tx_serial,
  input wire logic rxd_pin_in,
  output logic rxd_pin_out,
  output logic rxd_pin_oe,
  output logic txd_pin_out,
  output logic txd_pin_oe,
  input wire logic gpio_rx_out,
  input wire logic gpio_rx_oe,
  input wire logic gpio_tx_out,
  input wire logic gpio_tx_oe,
  output logic gpio_rx_in,
  output logic rx_serial,
  output logic rx_enable,
  output logic tx_enable,
  output logic rx_full_flag,
  output logic framing_error_flag,
  output logic overrun_error_flag,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_empty_irq,
  output logic irq
);

  // ==========================================================
  // Bus and register state
  serial_port_pkg::bus_st_e st_q, st_d;
  logic [7:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic rdy_q, rdy_d;
  serial_port_pkg::word_t rdata_q, rdata_d;
  logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`EV_W-1:0] ev_q, ev_d;
  logic [`EV_W-1:0] ien_q, ien_d;
  logic resp_q;

  // ==========================================================
  // Receive flag and request state
  logic full_q, full_d;
  logic fer_q, fer_d;
  logic oer_q, oer_d;
  logic rxi_q, rxi_d;
  logic eri_q, eri_d;
  logic txi_q, txi_d;
  logic irq_q, irq_d;

  // ==========================================================
  // Pin state
  logic s1_q, s2_q, s3_q;
  logic pin_q, pin_d;
  logic rxo_q, rxo_d, rxoe_q, rxoe_d;
  logic txo_q, txo_d, txoe_q, txoe_d;
  logic gin_q, gin_d, rser_q, rser_d;

  logic take;
  logic wr_now;
  logic frame_ok;
  logic mp_clear;
  logic [`EV_W-1:0] lvl_d;
  logic [`EV_W-1:0] lvl_q;
  logic [`EV_W-1:0] ev_nxt;
  logic clr_wr;

  assign take = hsel && hready && htrans[1];
  assign wr_now = (st_q == serial_port_pkg::BUS_WAIT) && wr_q;

  // ==========================================================
  // Sticky events, one per request line
  assign lvl_d[`EV_RX_FULL] = rxi_d;
  assign lvl_d[`EV_RX_ERR] = eri_d;
  assign lvl_d[`EV_TX_EMPTY] = txi_d;

  assign lvl_q[`EV_RX_FULL] = rxi_q;
  assign lvl_q[`EV_RX_ERR] = eri_q;
  assign lvl_q[`EV_TX_EMPTY] = txi_q;
  assign clr_wr = wr_now && (addr_q == `OFS_IRQ_CLR);

  for (genvar k = 0; k < `EV_W; k++) begin : g_ev
    // A new event wins over a clear in the same cycle
    assign ev_nxt[k] = (lvl_d[k] && !lvl_q[k]) ||
      (ev_q[k] && !(clr_wr && hwdata[k]));
  end

  // ==========================================================
  // Receive frame acceptance
  always_comb begin
    frame_ok = frame_valid && ctrl_q[`CTRL_RX_EN];
    mp_clear = frame_ok && ctrl_q[`CTRL_MP_IRQ_EN] && frame_mp_bit;
    if (ctrl_q[`CTRL_MP_IRQ_EN] && !frame_mp_bit) begin
      frame_ok = 1'b0;
    end
  end

  // ==========================================================
  // Bus slave and registers, next values
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wr_d = wr_q;
    rdy_d = rdy_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    ev_d = ev_q;
    unique case (st_q)
      serial_port_pkg::BUS_IDLE: begin
        rdy_d = 1'b1;
        if (take) begin
          addr_d = haddr[7:0];
          wr_d = hwrite;
          rdy_d = 1'b0;
          st_d = serial_port_pkg::BUS_WAIT;
        end
      end
      serial_port_pkg::BUS_WAIT: begin
        rdy_d = 1'b1;
        st_d = serial_port_pkg::BUS_IDLE;
        rdata_d = 32'h00000000;
        if (!wr_q) begin
          unique case (addr_q)
            `OFS_CTRL: rdata_d[`CTRL_W-1:0] = ctrl_q;
            `OFS_STATUS: rdata_d[3:0] = {tx_reg_empty, oer_q, fer_q, full_q};
            `OFS_IRQ_STAT: rdata_d[`EV_W-1:0] = ev_q;
            `OFS_IRQ_EN: rdata_d[`EV_W-1:0] = ien_q;
            default: rdata_d = 32'h00000000;
          endcase
        end else if (addr_q == `OFS_CTRL) begin
          ctrl_d = hwdata[`CTRL_W-1:0];
        end else if (addr_q == `OFS_IRQ_EN) begin
          ien_d = hwdata[`EV_W-1:0];
        end
      end
    endcase
    if (mp_clear) begin
      ctrl_d[`CTRL_MP_IRQ_EN] = 1'b0;
    end
    ev_d = ev_nxt;
  end

  // ==========================================================
  // Status flags and interrupt requests, next values
  always_comb begin
    full_d = full_q;
    fer_d = fer_q;
    oer_d = oer_q;
    if (wr_now && addr_q == `OFS_STATUS) begin
      full_d = full_q & ~hwdata[`ST_RX_FULL];
      fer_d = fer_q & ~hwdata[`ST_FER];
      oer_d = oer_q & ~hwdata[`ST_OER];
    end
    if (frame_ok) begin
      full_d = 1'b1;
      fer_d = fer_d | frame_fer;
      oer_d = oer_d | frame_oer;
    end
    rxi_d = ctrl_q[`CTRL_RX_IRQ_EN] && !ctrl_q[`CTRL_MP_IRQ_EN] && full_q;
    eri_d = ctrl_q[`CTRL_RX_IRQ_EN] && !ctrl_q[`CTRL_MP_IRQ_EN] &&
      (fer_q || oer_q);
    txi_d = ctrl_q[`CTRL_TX_IRQ_EN] && ctrl_q[`CTRL_TX_EN] && tx_reg_empty;
    irq_d = |(ev_q & ien_q);
  end

  // ==========================================================
  // Pin hand-over, next values
  always_comb begin
    pin_d = (s2_q == s3_q) ? s3_q : pin_q;
    if (ctrl_q[`CTRL_RX_EN]) begin
      rxo_d = 1'b0;
      rxoe_d = 1'b0;
      rser_d = pin_q;
      gin_d = 1'b0;
    end else begin
      rxo_d = gpio_rx_out;
      rxoe_d = gpio_rx_oe;
      rser_d = 1'b1;
      gin_d = pin_q;
    end
    if (ctrl_q[`CTRL_TX_EN]) begin
      txo_d = tx_serial;
      txoe_d = 1'b1;
    end else begin
      txo_d = gpio_tx_out;
      txoe_d = gpio_tx_oe;
    end
  end

  // ==========================================================
  // Bus and register flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= serial_port_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rdy_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q <= `CTRL_RESET;
      ien_q <= `EV_RESET;
      ev_q <= `EV_RESET;
      resp_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      rdy_q <= rdy_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      ev_q <= ev_d;
      resp_q <= 1'b0;
    end
  end

  // ==========================================================
  // Flag and request flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      full_q <= 1'b0;
      fer_q <= 1'b0;
      oer_q <= 1'b0;
      rxi_q <= 1'b0;
      eri_q <= 1'b0;
      txi_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      full_q <= full_d;
      fer_q <= fer_d;
      oer_q <= oer_d;
      rxi_q <= rxi_d;
      eri_q <= eri_d;
      txi_q <= txi_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // Receive pin synchroniser, three stages
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else if (ce) begin
      s1_q <= rxd_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Pin hand-over flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_q <= 1'b1;
      rxo_q <= 1'b0;
      rxoe_q <= 1'b0;
      txo_q <= 1'b1;
      txoe_q <= 1'b0;
      gin_q <= 1'b0;
      rser_q <= 1'b1;
    end else if (ce) begin
      pin_q <= pin_d;
      rxo_q <= rxo_d;
      rxoe_q <= rxoe_d;
      txo_q <= txo_d;
      txoe_q <= txoe_d;
      gin_q <= gin_d;
      rser_q <= rser_d;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp = resp_q;
  assign rxd_pin_out = rxo_q;
  assign rxd_pin_oe = rxoe_q;
  assign txd_pin_out = txo_q;
  assign txd_pin_oe = txoe_q;
  assign gpio_rx_in = gin_q;
  assign rx_serial = rser_q;
  assign rx_enable = ctrl_q[`CTRL_RX_EN];
  assign tx_enable = ctrl_q[`CTRL_TX_EN];
  assign rx_full_flag = full_q;
  assign framing_error_flag = fer_q;
  assign overrun_error_flag = oer_q;
  assign rx_full_irq = rxi_q;
  assign rx_error_irq = eri_q;
  assign tx_empty_irq = txi_q;
  assign irq = irq_q;

endmodule

/* dv/serial_port_sva.sv */
// Purpose: port assertions of the serial control block
// Assumes: inputs stand still while ce is low
// Notes: bound to the top module
`timescale 1ns/10ps
// ==========================================================
// Checker
module serial_port_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic frame_valid,
  input wire logic tx_reg_empty,
  input wire logic tx_serial,
  input wire logic gpio_tx_oe,
  input wire logic rxd_pin_oe,
  input wire logic txd_pin_out,
  input wire logic txd_pin_oe,
  input wire logic gpio_rx_in,
  input wire logic rx_serial,
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire logic rx_full_flag,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic rx_full_irq,
  input wire logic rx_error_irq,
  input wire logic tx_empty_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rx_off_pin: assert property (
    (!rx_enable && $past(!rx_enable)) |-> rx_serial) else $error("rx off");
  a_rx_on_pin: assert property (
    (rx_enable && $past(rx_enable)) |-> !rxd_pin_oe && !gpio_rx_in)
    else $error("rx on");
  a_tx_on_pin: assert property (
    (tx_enable && $past(tx_enable)) |->
    txd_pin_oe && txd_pin_out == $past(tx_serial)) else $error("tx on");
  a_tx_off_pin: assert property (
    (!tx_enable && $past(!tx_enable) && $past(resetn)) |->
    txd_pin_oe == $past(gpio_tx_oe)) else $error("tx off");
  a_flag_cause: assert property (
    $rose(rx_full_flag) |-> $past(frame_valid && rx_enable))
    else $error("flag cause");
  a_full_irq_gate: assert property (
    rx_full_irq |-> $past(rx_full_flag)) else $error("full irq");
  a_err_irq_gate: assert property (
    rx_error_irq |-> $past(framing_error_flag || overrun_error_flag))
    else $error("err irq");
  a_tx_irq_gate: assert property (
    tx_empty_irq |-> $past(tx_reg_empty && tx_enable)) else $error("tx irq");
endmodule

bind serial_port_control_enables serial_port_sva i_serial_port_sva (.*);

/* dv/serial_node_model.sv */
// Purpose: remote serial node driving the receive line
// Assumes: line idles high through a pull-up
// Notes: sends the level chosen by the bench
`timescale 1ns/10ps
module serial_node_model (
  input wire logic clk,
  input wire logic send,
  input wire logic bit_val,
  output logic rxd
);
  logic q;
  always_ff @(posedge clk) begin
    q <= bit_val;
  end
  assign rxd = send ? q : 1'b1;
endmodule

/* dv/tb_serial_port_control_enables.sv */
// Purpose: self-checking bench of the serial control block
// Assumes: ce high except while one frame is sent, word transfers only
// Notes: random frames with fixed seed
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module tb_serial_port_control_enables;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic frame_valid = 1'b0, frame_mp_bit = 1'b0, frame_fer = 1'b0;
  logic frame_oer = 1'b0, tx_reg_empty = 1'b0, tx_serial = 1'b1;
  logic gpio_rx_out = 1'b0, gpio_rx_oe = 1'b0, gpio_tx_out = 1'b0;
  logic gpio_tx_oe = 1'b0, send = 1'b0, bit_val = 1'b1, ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic hreadyout, hresp, node_rxd, rxd_w, rxd_pin_out, rxd_pin_oe;
  logic txd_pin_out, txd_pin_oe, gpio_rx_in, rx_serial, rx_enable;
  logic tx_enable, rx_full_flag, framing_error_flag, overrun_error_flag;
  logic rx_full_irq, rx_error_irq, tx_empty_irq, irq;
  int errors = 0, comparisons = 0;
  always #10 clk = ~clk;
  assign rxd_w = rxd_pin_oe ? rxd_pin_out : node_rxd;
  serial_port_control_enables i_serial_port_control_enables (.*,
    .ce(ce), .hsize(3'h2), .hready(hreadyout), .rxd_pin_in(rxd_w));
  serial_node_model i_serial_node_model (.clk(clk), .send(send),
    .bit_val(bit_val), .rxd(node_rxd));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task frm(input logic [2:0] f);
    frame_valid <= 1'b1;
    {frame_oer, frame_fer, frame_mp_bit} <= f;
    @(posedge clk);
    frame_valid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  function automatic logic [2:0] exp_st(logic rx, me, logic [2:0] f);
    return {f[2:1], 1'b1} & {3{rx & (~me | f[0])}};
  endfunction
  task end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  initial begin
    logic [4:0] c;
    logic [2:0] f, e;
    logic m, g;
    void'($urandom(32'h7660bcc9));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, rv);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rv);
    for (int i = 0; i < 4; i++) begin
      bit_val <= i[0];
      send <= 1'b1;
      bus(1'b1, `OFS_CTRL, {31'h0, i[1]});
      repeat (8) @(posedge clk);
      chk("gpio_rx_in", i[1] ? 1'b0 : i[0], gpio_rx_in);
      chk("rx_serial", i[1] ? i[0] : 1'b1, rx_serial);
      chk("rx_enable", i[1], rx_enable);
    end
    for (int i = 0; i < 8; i++) begin
      {tx_serial, gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe} <=
        5'($urandom);
      bus(1'b1, `OFS_CTRL, {30'h0, i[0], i[1]});
      repeat (3) @(posedge clk);
      chk("tx_enable", i[0], tx_enable);
      chk("rxd_out", i[1] ? 1'b0 : gpio_rx_out, rxd_pin_out);
      chk("rxd_oe", i[1] ? 1'b0 : gpio_rx_oe, rxd_pin_oe);
      chk("txd_out", i[0] ? tx_serial : gpio_tx_out, txd_pin_out);
      chk("txd_oe", i[0] | gpio_tx_oe, txd_pin_oe);
    end
    for (int i = 0; i < 40; i++) begin
      c = 5'($urandom) & 5'h15;
      f = 3'($urandom);
      bus(1'b1, `OFS_CTRL, {27'h0, c});
      frm(f);
      e = exp_st(c[0], c[4], f);
      m = c[4] & ~(c[0] & f[0]);
      g = c[2] & ~m;
      chk("full_irq", e[0] & g, rx_full_irq);
      chk("err_irq", (e[1] | e[2]) & g, rx_error_irq);
      chk("flags", e,
        {overrun_error_flag, framing_error_flag, rx_full_flag});
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("status", e, rv[2:0]);
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk("mp_en", m, rv[4]);
      bus(1'b1, `OFS_STATUS, 32'h7);
    end
    bus(1'b1, `OFS_CTRL, 32'h1);
    ce <= 1'b0;
    frm(3'h0);
    ce <= 1'b1;
    chk("ce_hold", 1'b0, rx_full_flag);
    tx_reg_empty <= 1'b1;
    bus(1'b1, `OFS_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk("txi_off", 1'b0, tx_empty_irq);
    bus(1'b1, `OFS_CTRL, 32'hA);
    repeat (2) @(posedge clk);
    chk("txi_on", 1'b1, tx_empty_irq);
    bus(1'b1, `OFS_IRQ_EN, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq", 1'b1, irq);
    bus(1'b1, `OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq_mask", 1'b0, irq);
    tx_reg_empty <= 1'b0;
    bus(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("stat_set", 1'b1, rv[2]);
    bus(1'b1, `OFS_IRQ_CLR, 32'h7);
    bus(1'b1, `OFS_IRQ_EN, 32'h4);
    bus(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("stat_clr", 32'h0, rv);
    chk("irq_clr", 1'b0, irq);
    end_sim;
  end
endmodule
